// ### core/tcsr_pkg.sv
// Shared constants for the touch controller startup and reset pair.
// Assumes a single 250 MHz clock shared by both ends of the link.
package tcsr_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_KHZ         = 250000;
  localparam int CLK_PERIOD_NS   = 4;
  localparam int TMR_W           = 27;
  localparam int RDY_POR_MIN_MS  = 135;
  localparam int RDY_POR_MAX_MS  = 430;
  localparam int RDY_SW_MIN_MS   = 155;
  localparam int RDY_SW_MAX_MS   = 460;
  localparam int CHG_FLOAT_MS    = 100;
  localparam int RST_MIN_NS      = 90;
  localparam int HOST_SETTLE_MS  = 1;
  localparam int HOST_RAMP_MS    = 10;
  localparam logic [TMR_W-1:0] RDY_POR_MIN_CYC = TMR_W'(RDY_POR_MIN_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] RDY_POR_MAX_CYC = TMR_W'(RDY_POR_MAX_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] RDY_SW_MIN_CYC  = TMR_W'(RDY_SW_MIN_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] RDY_SW_MAX_CYC  = TMR_W'(RDY_SW_MAX_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] CHG_FLOAT_CYC   = TMR_W'(CHG_FLOAT_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] SETTLE_CYC      = TMR_W'(HOST_SETTLE_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] RAMP_CYC        = TMR_W'(HOST_RAMP_MS * CLK_KHZ);
  localparam logic [4:0] RST_MIN_CYC =
    5'((RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // Supply vector bits
  localparam int SUP_CORE   = 0;
  localparam int SUP_ANALOG = 1;
  localparam int SUP_IO     = 2;
  localparam int NSUP       = 3;

  // ==========================================================
  // Host register map
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam int CTRL_PWR_ON = 0;
  localparam int CTRL_HW_RST = 1;
  localparam int CTRL_SW_RST = 2;
  localparam int EV_READY    = 0;
  localparam int EV_FLAG     = 1;
  localparam int EV_LATE     = 2;
  localparam int NEV         = 3;
  localparam logic [NEV-1:0] IRQ_MASK_RST = 3'h0;

  // ==========================================================
  // State machines
  typedef enum logic [1:0] {DEV_OFF, DEV_INIT, DEV_READY} tcsr_dev_state_t;
  typedef enum logic [2:0] {HST_OFF, HST_RAMP, HST_HOLD, HST_WAIT,
                            HST_READ, HST_RESP, HST_RUN} tcsr_hst_state_t;

endpackage

// ### core/tcsr_link_if.sv
// Link between the touch controller and its host controller.
// Assumes both ends run on the same clock; the change line has a pull-up.
interface tcsr_link_if;
  logic reset_n;            // Host drives the reset pin
  logic sw_reset_cmd;       // Reset command to command_processor_object
  logic msg_rd;             // Host reads the pending message
  logic msg_reset_flag;     // Reset flag of the message, cycle after msg_rd
  logic chg_o;
  logic chg_oe;
  logic message_pending_n;  // Resolved change line

  // Pull-up holds the line high whenever the device is not driving it
  assign message_pending_n = chg_oe ? chg_o : 1'b1;

  modport dev (input reset_n, input sw_reset_cmd, input msg_rd,
               output msg_reset_flag, output chg_o, output chg_oe);
  modport hst (output reset_n, output sw_reset_cmd, output msg_rd,
               input msg_reset_flag, input message_pending_n);
endinterface

// ### core/tcsr_dev.sv
// Touch controller startup and reset sequencer, device end.
// Assumes supply-good levels arrive asynchronously from analog monitors,
// and that the link strobes come from logic on the same clock.
//
// How it works
// - Internal power-on reset initializes without external help
// - Host holds reset low during supply ramp
// - Ready 135 to 430 ms after reset
// - No init or talk without all supplies
// - Host recovers late analog supply by command
// - Reset pin low 90 ns resets device
// - Software reset command; ready 155 to 460 ms
// - Change line low when reset finishes
// - Reset flag set in command message
// - Change line floats first 100 ms
// - Power-on runs the enabled self tests
// - Host resets by pin, not power removal
// - Host switches supplies and reset line
module tcsr_dev
  import tcsr_pkg::*;
#(
  parameter logic [tcsr_pkg::TMR_W-1:0] RDY_POR_MIN = tcsr_pkg::RDY_POR_MIN_CYC,
  parameter logic [tcsr_pkg::TMR_W-1:0] RDY_POR_MAX = tcsr_pkg::RDY_POR_MAX_CYC,
  parameter logic [tcsr_pkg::TMR_W-1:0] RDY_SW_MIN  = tcsr_pkg::RDY_SW_MIN_CYC,
  parameter logic [tcsr_pkg::TMR_W-1:0] RDY_SW_MAX  = tcsr_pkg::RDY_SW_MAX_CYC,
  parameter logic [tcsr_pkg::TMR_W-1:0] CHG_FLOAT   = tcsr_pkg::CHG_FLOAT_CYC
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  tcsr_link_if.dev   link,
  input  wire logic  core_supply_ok,
  input  wire logic  analog_supply_ok,
  input  wire logic  io_supply_ok,
  input  wire logic  long_config,
  input  wire logic  self_test_en,
  output logic       self_test_start,
  output logic       dev_ready,
  output logic       reset_flag
);

  // ==========================================================
  // Supply monitors
  wire [NSUP-1:0] sup_pin = {io_supply_ok, analog_supply_ok, core_supply_ok};
  wire [NSUP-1:0] sup_ok;

  genvar gi;
  for (gi = 0; gi < NSUP; gi++) begin : g_sync
    logic s1_reg, s2_reg, s3_reg, ok_reg, ok_next;
    // Only agreed samples count, so a single metastable sample is ignored
    always_comb begin
      ok_next = (s2_reg == s3_reg) ? s3_reg : ok_reg;
    end
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
        ok_reg <= 1'b0;
      end else begin
        s1_reg <= sup_pin[gi];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        ok_reg <= ok_next;
      end
    end
    assign sup_ok[gi] = ok_reg;
  end

  wire all_ok = &sup_ok;

  // ==========================================================
  // Sequencer
  tcsr_dev_state_t   state_reg, state_next;
  logic [TMR_W-1:0]  tmr_reg, tmr_next;
  logic [4:0]        low_cnt_reg, low_cnt_next;
  logic              held_reg, held_next;
  logic              por_reg, por_next;
  logic              sw_cause_reg, sw_cause_next;
  logic              flag_reg, flag_next;
  logic              msg_reg, msg_next;
  logic              chg_o_reg, chg_o_next;
  logic              chg_oe_reg, chg_oe_next;
  logic              st_reg, st_next;
  logic              rdy_reg, rdy_next;
  logic [TMR_W-1:0]  limit;
  logic              pin_hit;

  // Ready delay depends on the cause and on the size of the configuration
  always_comb begin
    if (sw_cause_reg) begin
      limit = long_config ? RDY_SW_MAX : RDY_SW_MIN;
    end else begin
      limit = long_config ? RDY_POR_MAX : RDY_POR_MIN;
    end
  end

  // Glitches shorter than the least pulse are filtered out
  always_comb begin
    low_cnt_next = low_cnt_reg;
    if (link.reset_n) begin
      low_cnt_next = 5'h00;
    end else if (low_cnt_reg != RST_MIN_CYC) begin
      low_cnt_next = low_cnt_reg + 5'h01;
    end
  end
  assign pin_hit = !link.reset_n && (low_cnt_next == RST_MIN_CYC);

  always_comb begin
    state_next    = state_reg;
    tmr_next      = tmr_reg;
    held_next     = held_reg;
    por_next      = por_reg;
    sw_cause_next = sw_cause_reg;
    flag_next     = flag_reg;
    msg_next      = msg_reg;
    st_next       = 1'b0;
    if (link.reset_n) begin
      held_next = 1'b0;
    end
    if (!all_ok) begin
      por_next = 1'b1;
    end
    if (pin_hit || !all_ok) begin
      // Pin reset and supply loss share one path back to the start
      state_next    = DEV_OFF;
      tmr_next      = '0;
      held_next     = pin_hit;
      sw_cause_next = 1'b0;
      flag_next     = 1'b0;
    end else begin
      unique case (state_reg)
        DEV_OFF: begin
          // Count only once supplies are good and the pin is released
          if (link.reset_n && !held_next) begin
            state_next = DEV_INIT;
            tmr_next   = '0;
            st_next    = por_reg && self_test_en;
            por_next   = 1'b0;
          end
        end
        DEV_INIT: begin
          if (tmr_reg == limit - TMR_W'(1)) begin
            state_next = DEV_READY;
            flag_next  = 1'b1;
          end else begin
            tmr_next = tmr_reg + TMR_W'(1);
          end
        end
        DEV_READY: begin
          // Host talks to the device only once it is ready
          if (link.msg_rd) begin
            msg_next  = flag_reg;
            flag_next = 1'b0;
          end else if (link.sw_reset_cmd) begin
            state_next    = DEV_INIT;
            tmr_next      = '0;
            sw_cause_next = 1'b1;
            flag_next     = 1'b0;
          end
        end
      endcase
    end
  end

  // Change line follows the next state so the pins come from flops
  always_comb begin
    chg_o_next  = 1'b1;
    chg_oe_next = 1'b0;
    rdy_next    = (state_next == DEV_READY);
    unique case (state_next)
      DEV_OFF: begin
        chg_oe_next = 1'b0;
      end
      DEV_INIT: begin
        chg_oe_next = (tmr_next >= CHG_FLOAT);
      end
      DEV_READY: begin
        chg_oe_next = 1'b1;
        chg_o_next  = !flag_next;
      end
    endcase
  end

  // Synchronous reset is the internal power-on reset of the device
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg    <= DEV_OFF;
      tmr_reg      <= '0;
      low_cnt_reg  <= 5'h00;
      held_reg     <= 1'b0;
      por_reg      <= 1'b1;
      sw_cause_reg <= 1'b0;
      flag_reg     <= 1'b0;
      msg_reg      <= 1'b0;
      chg_o_reg    <= 1'b1;
      chg_oe_reg   <= 1'b0;
      st_reg       <= 1'b0;
      rdy_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      tmr_reg      <= tmr_next;
      low_cnt_reg  <= low_cnt_next;
      held_reg     <= held_next;
      por_reg      <= por_next;
      sw_cause_reg <= sw_cause_next;
      flag_reg     <= flag_next;
      msg_reg      <= msg_next;
      chg_o_reg    <= chg_o_next;
      chg_oe_reg   <= chg_oe_next;
      st_reg       <= st_next;
      rdy_reg      <= rdy_next;
    end
  end

  assign link.chg_o          = chg_o_reg;
  assign link.chg_oe         = chg_oe_reg;
  assign link.msg_reset_flag = msg_reg;
  assign self_test_start     = st_reg;
  assign dev_ready           = rdy_reg;
  assign reset_flag          = flag_reg;

endmodule // tcsr_dev

// ### core/tcsr_host.sv
// Host controller end: switches supplies, drives the reset pin, reads messages.
// Assumes supply-good levels arrive asynchronously; register port on clk.
//
// Added by the designer: strobed register access and the placing of the registers.
module tcsr_host
  import tcsr_pkg::*;
#(
  parameter logic [tcsr_pkg::TMR_W-1:0] SETTLE = tcsr_pkg::SETTLE_CYC,
  parameter logic [tcsr_pkg::TMR_W-1:0] RAMP   = tcsr_pkg::RAMP_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  tcsr_link_if.hst                  link,
  input  wire logic [7:0]           addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [31:0]          rdata,
  input  wire logic [tcsr_pkg::NSUP-1:0] supply_good,
  output logic      [tcsr_pkg::NSUP-1:0] supply_en,
  output logic                      irq
);

  // ==========================================================
  // Supply good synchronisers
  wire [NSUP-1:0] sg;
  genvar gi;
  for (gi = 0; gi < NSUP; gi++) begin : g_sync
    logic s1_reg, s2_reg, s3_reg, ok_reg, ok_next;
    always_comb begin
      ok_next = (s2_reg == s3_reg) ? s3_reg : ok_reg;
    end
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
        ok_reg <= 1'b0;
      end else begin
        s1_reg <= supply_good[gi];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        ok_reg <= ok_next;
      end
    end
    assign sg[gi] = ok_reg;
  end

  function automatic logic ctrl_hit(input logic [7:0] a, input logic w,
                                    input logic [31:0] d, input int b);
    ctrl_hit = w && (a == REG_CTRL) && d[b];
  endfunction

  // ==========================================================
  // Sequencer
  tcsr_hst_state_t  state_reg, state_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic             rst_n_reg, rst_n_next;
  logic             swc_reg, swc_next;
  logic             mrd_reg, mrd_next;
  logic             late_reg, late_next;
  logic             flag_reg, flag_next;
  logic [NEV-1:0]   ev;
  logic             pwr_off;

  assign pwr_off = wr && (addr == REG_CTRL) && !wdata[CTRL_PWR_ON];

  always_comb begin
    state_next = state_reg;
    tmr_next   = tmr_reg;
    rst_n_next = rst_n_reg;
    swc_next   = 1'b0;
    mrd_next   = 1'b0;
    late_next  = late_reg;
    flag_next  = flag_reg;
    ev         = '0;
    if (pwr_off) begin
      // Reset goes low together with the supplies, never left high
      state_next = HST_OFF;
      rst_n_next = 1'b0;
    end else begin
      unique case (state_reg)
        HST_OFF: begin
          rst_n_next = 1'b0;
          if (ctrl_hit(addr, wr, wdata, CTRL_PWR_ON)) begin
            state_next = HST_RAMP;
            tmr_next   = '0;
            late_next  = 1'b0;
          end
        end
        HST_RAMP: begin
          // Reset stays low until every supply is good and settled, or until RAMP runs out
          if (tmr_reg != RAMP) begin
            tmr_next = tmr_reg + TMR_W'(1);
          end
          if ((&sg && tmr_reg >= SETTLE) || tmr_reg == RAMP) begin
            state_next = HST_WAIT;
            rst_n_next = 1'b1;
            late_next  = !sg[SUP_ANALOG];
            ev[EV_LATE] = !sg[SUP_ANALOG];
          end
        end
        HST_HOLD: begin
          if (tmr_reg == TMR_W'(RST_MIN_CYC) - TMR_W'(1)) begin
            state_next = HST_WAIT;
            rst_n_next = 1'b1;
          end else begin
            tmr_next = tmr_reg + TMR_W'(1);
          end
        end
        HST_WAIT: begin
          // Change line is only read, never driven
          if (!link.message_pending_n) begin
            state_next = HST_READ;
            mrd_next   = 1'b1;
          end
        end
        HST_READ: begin
          state_next = HST_RESP;
        end
        HST_RESP: begin
          flag_next   = link.msg_reset_flag;
          ev[EV_FLAG] = link.msg_reset_flag;
          if (late_reg) begin
            // Late analog supply: recover with a reset command
            state_next = HST_WAIT;
            swc_next   = 1'b1;
            late_next  = 1'b0;
          end else begin
            state_next   = HST_RUN;
            ev[EV_READY] = 1'b1;
          end
        end
        HST_RUN: begin
          if (!link.message_pending_n) begin
            state_next = HST_READ;
            mrd_next   = 1'b1;
          end else if (ctrl_hit(addr, wr, wdata, CTRL_HW_RST)) begin
            state_next = HST_HOLD;
            rst_n_next = 1'b0;
            tmr_next   = '0;
          end else if (ctrl_hit(addr, wr, wdata, CTRL_SW_RST)) begin
            state_next = HST_WAIT;
            swc_next   = 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Registers and interrupt
  logic [NEV-1:0] stat_reg, stat_next, mask_reg, mask_next;
  logic [31:0]    rdata_next;
  logic [NSUP-1:0] en_next, en_reg;
  logic           irq_next, irq_reg;

  always_comb begin
    mask_next  = mask_reg;
    stat_next  = stat_reg;
    rdata_next = 32'h0000_0000;
    en_next    = (state_next == HST_OFF) ? '0 : '1;
    if (wr && addr == REG_IRQ_MASK) begin
      mask_next = wdata[NEV-1:0];
    end
    if (rd) begin
      unique case (addr)
        REG_CTRL:     rdata_next = {31'h0, state_reg != HST_OFF};
        REG_STATUS:   rdata_next = {29'h0, late_reg, flag_reg, state_reg == HST_RUN};
        REG_IRQ_STAT: rdata_next = {29'h0, stat_reg};
        REG_IRQ_MASK: rdata_next = {29'h0, mask_reg};
        default:      rdata_next = 32'h0000_0000;
      endcase
      if (addr == REG_IRQ_STAT) begin
        stat_next = '0;
      end
    end
    // An event in the clearing cycle survives the read
    stat_next = stat_next | ev;
    irq_next  = |(stat_next & mask_next);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= HST_OFF;
      tmr_reg   <= '0;
      rst_n_reg <= 1'b0;
      swc_reg   <= 1'b0;
      mrd_reg   <= 1'b0;
      late_reg  <= 1'b0;
      flag_reg  <= 1'b0;
      stat_reg  <= '0;
      mask_reg  <= IRQ_MASK_RST;
      rdata     <= 32'h0000_0000;
      en_reg    <= '0;
      irq_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg   <= tmr_next;
      rst_n_reg <= rst_n_next;
      swc_reg   <= swc_next;
      mrd_reg   <= mrd_next;
      late_reg  <= late_next;
      flag_reg  <= flag_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      rdata     <= rdata_next;
      en_reg    <= en_next;
      irq_reg   <= irq_next;
    end
  end

  assign link.reset_n      = rst_n_reg;
  assign link.sw_reset_cmd = swc_reg;
  assign link.msg_rd       = mrd_reg;
  assign supply_en         = en_reg;
  assign irq               = irq_reg;

endmodule // tcsr_host

// ### tb/tcsr_link_checker.sv
// Concurrent checks on the link between the touch controller and its host.
// Assumes one clock and a synchronous active-low reset shared by both ends.
module tcsr_link_checker #(
  parameter int CHG_FLOAT = 50,
  parameter int RDY_LO    = 200,
  parameter int RDY_HI    = 460
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_n,
  input wire logic sw_reset_cmd,
  input wire logic msg_rd,
  input wire logic msg_reset_flag,
  input wire logic chg_o,
  input wire logic chg_oe,
  input wire logic message_pending_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Float window eats the start of the ready delay; two cycles of slack each side
  localparam int W_LO = RDY_LO - CHG_FLOAT - 2;
  localparam int W_HI = RDY_HI - CHG_FLOAT + 2;
  logic [9:0] hi_cnt_reg, hi_cnt_next, lo_cnt_reg, lo_cnt_next, oe_cnt_reg, oe_cnt_next;
  logic       served_reg, served_next;

  // ==========================================================
  // Helper counters
  always_comb begin
    hi_cnt_next = reset_n ? hi_cnt_reg + 10'(hi_cnt_reg != 10'h3ff) : 10'h0;
    lo_cnt_next = reset_n ? 10'h0 : lo_cnt_reg + 10'(lo_cnt_reg != 10'h3ff);
    oe_cnt_next = chg_oe ? oe_cnt_reg + 10'(oe_cnt_reg != 10'h3ff) : 10'h0;
    served_next = chg_oe && (served_reg || (msg_rd && !message_pending_n));
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_cnt_reg <= 10'h0;
      lo_cnt_reg <= 10'h0;
      oe_cnt_reg <= 10'h0;
      served_reg <= 1'b0;
    end else begin
      hi_cnt_reg <= hi_cnt_next;
      lo_cnt_reg <= lo_cnt_next;
      oe_cnt_reg <= oe_cnt_next;
      served_reg <= served_next;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_FLOAT_HOLD: assert property (
    $rose(chg_oe) |-> hi_cnt_reg >= CHG_FLOAT && chg_o) else $error("change line driven early");
  AST_RST_QUIET: assert property (
    $rose(reset_n) |-> !chg_oe [*8]) else $error("change line driven at pin release");
  AST_PIN_RESET: assert property (
    lo_cnt_reg >= 23 |-> !chg_oe) else $error("long reset pulse did not reset device");
  AST_RDY_SOON: assert property (
    $rose(chg_oe) |-> ##[1:W_HI] (!chg_o || !chg_oe)) else $error("ready too late");
  AST_RDY_WINDOW: assert property (
    $fell(message_pending_n) |-> oe_cnt_reg >= W_LO && oe_cnt_reg <= W_HI)
    else $error("ready outside delay window");
  AST_MSG_ANSWER: assert property (
    msg_rd && !message_pending_n |=> msg_reset_flag && message_pending_n)
    else $error("message read gave no reset flag");
  AST_SW_TAKEN: assert property (
    sw_reset_cmd && !msg_rd && chg_oe && (served_reg || !chg_o) |=> !chg_oe)
    else $error("reset command not taken");
  AST_ONE_MSG: assert property (
    served_reg && chg_oe |-> chg_o) else $error("change line low after message read");
  cover property (msg_rd && !message_pending_n);
  cover property (sw_reset_cmd && chg_oe);
  cover property (lo_cnt_reg == 10'd23);
endmodule // tcsr_link_checker

// ### tb/tb_top.sv
// Self-checking bench: host and device joined by the link interface.
// Assumes the host register port and a supply model made from supply_en.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tcsr_pkg::*;
  localparam int POR_MIN = 200, POR_MAX = 400, SW_MIN = 220, SW_MAX = 460;
  logic        clk, rst_n, wr, rd, long_config, self_test_en, self_test_start;
  logic        dev_ready, reset_flag, irq;
  logic        rd_d = 1'b0;
  logic [7:0]  addr, ua;
  logic [31:0] wdata, rdata, rnd;
  logic [31:0] exp_q[$];
  logic [2:0]  supply_en, late_kill, dev_kill, sup;
  int          miscompares, n_tests, cyc, st_cnt, st0, t0;

  tcsr_link_if lnk();
  // Late analog is seen by both ends; dev_kill hides a supply from the device only
  assign sup = supply_en & ~late_kill;
  tcsr_dev #(.RDY_POR_MIN(TMR_W'(POR_MIN)), .RDY_POR_MAX(TMR_W'(POR_MAX)),
    .RDY_SW_MIN(TMR_W'(SW_MIN)), .RDY_SW_MAX(TMR_W'(SW_MAX)), .CHG_FLOAT(TMR_W'(50)))
  tcsr_dev_i (.clk(clk), .rst_n(rst_n), .link(lnk),
    .core_supply_ok(sup[SUP_CORE] & ~dev_kill[SUP_CORE]),
    .analog_supply_ok(sup[SUP_ANALOG] & ~dev_kill[SUP_ANALOG]),
    .io_supply_ok(sup[SUP_IO] & ~dev_kill[SUP_IO]), .long_config(long_config),
    .self_test_en(self_test_en), .self_test_start(self_test_start),
    .dev_ready(dev_ready), .reset_flag(reset_flag));
  tcsr_host #(.SETTLE(TMR_W'(10)), .RAMP(TMR_W'(100))) tcsr_host_i (.clk(clk),
    .rst_n(rst_n), .link(lnk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .supply_good(sup), .supply_en(supply_en), .irq(irq));
  tcsr_link_checker #(.CHG_FLOAT(50), .RDY_LO(POR_MIN), .RDY_HI(SW_MAX))
  tcsr_link_checker_i (.clk(clk), .rst_n(rst_n), .reset_n(lnk.reset_n),
    .sw_reset_cmd(lnk.sw_reset_cmd), .msg_rd(lnk.msg_rd), .msg_reset_flag(lnk.msg_reset_flag),
    .chg_o(lnk.chg_o), .chg_oe(lnk.chg_oe), .message_pending_n(lnk.message_pending_n));

  // ==========================================================
  // Clock, monitor and tasks
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_d <= rd;
    if (self_test_start === 1'b1) st_cnt <= st_cnt + 1;
    if (rd_d === 1'b1) check(rdata, exp_q.pop_front());
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // Bounded wait for a level; a timeout shows up as a mismatch
  task automatic wait_on(input int sel, input logic lvl);
    logic v;
    int   n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      case (sel)
        0: v = lnk.reset_n;
        1: v = lnk.sw_reset_cmd;
        2: v = lnk.message_pending_n;
        default: v = dev_ready;
      endcase
    end while (v !== lvl && n < 3000);
    if (v !== lvl) check(32'(sel), 32'hff);
  endtask
  task automatic span(input int t, input int lo, input int hi);
    check(32'(cyc - t >= lo && cyc - t <= hi), 32'h1);
  endtask
  // Let the host read the pending message and settle into its run state
  task automatic serve();
    wait_on(2, 1'b1);
    repeat (4) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (8000) @(posedge clk);
    miscompares++;
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h0; wdata = 32'h0;
    long_config = 1'b0; self_test_en = 1'b1; late_kill = 3'h0; dev_kill = 3'h0;
    rnd = $urandom(32'he795aa08);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rnd = $urandom;
    ua = 8'h10 | rnd[15:8];
    wreg(REG_IRQ_MASK, {29'h0, rnd[2:0]});
    rreg(REG_IRQ_MASK, {29'h0, rnd[2:0]});
    wreg(ua, 32'hffffffff);
    rreg(ua, 32'h0);
    wreg(REG_IRQ_MASK, 32'h3);
    // Power-on from cold
    st0 = st_cnt;
    wreg(REG_CTRL, 32'h1);
    @(negedge clk);
    check(32'({supply_en, lnk.reset_n}), 32'he);
    wait_on(0, 1'b1);
    t0 = cyc;
    wait_on(3, 1'b1);
    span(t0, POR_MIN, POR_MIN + 4);
    check(32'(lnk.message_pending_n), 32'h0);
    check(32'(reset_flag), 32'h1);
    check(32'(st_cnt - st0), 32'h1);
    serve();
    check(32'(irq), 32'h1);
    rreg(REG_STATUS, 32'h3);
    rreg(REG_IRQ_STAT, 32'h3);
    rreg(REG_IRQ_STAT, 32'h0);
    rreg(REG_CTRL, 32'h1);
    long_config <= 1'b1;
    @(negedge clk);
    check(32'(irq), 32'h0);
    // Pin reset with the long configuration
    st0 = st_cnt;
    wreg(REG_CTRL, 32'h3);
    wait_on(0, 1'b0);
    t0 = cyc;
    wait_on(0, 1'b1);
    span(t0, 23, 2000);
    t0 = cyc;
    wait_on(3, 1'b1);
    span(t0, POR_MAX, POR_MAX + 4);
    check(32'(st_cnt - st0), 32'h0);
    serve();
    rreg(REG_IRQ_STAT, 32'h3);
    // Reset command in both configurations; a pin reset during init is refused
    for (int i = 0; i < 2; i++) begin
      long_config <= i[0];
      wreg(REG_CTRL, 32'h5);
      wait_on(1, 1'b1);
      t0 = cyc;
      wreg(REG_CTRL, 32'h3);
      wait_on(3, 1'b1);
      span(t0, i ? SW_MAX : SW_MIN, (i ? SW_MAX : SW_MIN) + 4);
      check(32'(lnk.reset_n), 32'h1);
      serve();
      rreg(REG_STATUS, 32'h3);
    end
    // Supply lost under the device only: it drops out, then restarts as power-on
    dev_kill <= 3'h4;
    repeat (40) @(posedge clk);
    check(32'({dev_ready, lnk.message_pending_n}), 32'h1);
    st0 = st_cnt;
    dev_kill <= 3'h0;
    t0 = cyc;
    wait_on(3, 1'b1);
    span(t0, POR_MAX, POR_MAX + 6);
    check(32'(st_cnt - st0), 32'h1);
    serve();
    // Power off, then a late analog supply
    wreg(REG_CTRL, 32'h0);
    long_config <= 1'b0;
    late_kill <= 3'h2;
    @(negedge clk);
    check(32'({supply_en, lnk.reset_n}), 32'h0);
    wreg(REG_CTRL, 32'h1);
    wait_on(0, 1'b1);
    repeat (30) @(posedge clk);
    check(32'(dev_ready), 32'h0);
    late_kill <= 3'h0;
    t0 = cyc;
    wait_on(3, 1'b1);
    span(t0, POR_MIN, POR_MIN + 6);
    wait_on(1, 1'b1);
    t0 = cyc;
    wait_on(3, 1'b1);
    span(t0, SW_MIN, SW_MIN + 4);
    serve();
    rreg(REG_STATUS, 32'h3);
    rreg(REG_IRQ_STAT, 32'h7);
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule // tb_top
